// >>> design/mq_device.sv
// multi-queue device end: write/read queue selection, switch pipelines, flag buses
// assumes one common clock for both ports and a controller honouring selection spacing
`timescale 1ns/1ps
`include "mq_consts.svh"

module mq_device
    import mq_pkg::*;
#(
    parameter int WIDTH = `MQ_DATA_WIDTH,
    parameter int DEPTH = `MQ_QUEUE_DEPTH,
    parameter int AF_OFFSET = `MQ_FLAG_OFFSET,
    parameter int AE_OFFSET = `MQ_FLAG_OFFSET
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // strapped identity
    input wire logic [`MQ_ID_BITS-1:0] device_identity_pin,
    // port towards the controller
    mq_port_if.device port
);
    logic [`MQ_ID_BITS-1:0] id_s1, id_s2, id_s3;
    dev_id_t id_reg;

    logic st_wr, st_rd;
    logic [WIDTH-1:0] st_data;
    logic [`MQ_NUM_QUEUES-1:0] q_full, q_empty, q_afull, q_aempty;

    // write side state
    sw_phase_e wph_reg;
    qnum_t wq_reg, wq_new_reg;
    logic wact_reg, wact_new_reg;
    logic ff_n_reg, ff_oe_reg;
    logic paf_sel_reg;
    logic [`MQ_NUM_QUEUES-1:0] paf_reg;
    logic wsel, wmatch;
    qnum_t fview_q;
    logic fview_act;

    // read side state
    sw_phase_e rph_reg;
    qnum_t rq_reg, rq_new_reg;
    logic rok_reg, rok_new_reg, rdev_reg, rdev_new_reg;
    logic [WIDTH-1:0] pipe_reg, out_reg;
    logic pipe_v_reg, out_v_reg;
    logic oe_reg;
    logic pae_sel_reg;
    logic [`MQ_NUM_QUEUES-1:0] pae_reg;
    logic rsel, rmatch, advance, direct;

    // identity straps pass three stages; a value counts once the last two agree
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            id_s1 <= '0;
            id_s2 <= '0;
            id_s3 <= '0;
            id_reg <= '0;
        end else begin
            id_s1 <= device_identity_pin;
            id_s2 <= id_s1;
            id_s3 <= id_s2;
            if (id_s2 == id_s3) begin
                id_reg <= id_s3;
            end
        end
    end

    mq_queue_store #(
        .NQ(`MQ_NUM_QUEUES),
        .DEPTH(DEPTH),
        .WIDTH(WIDTH),
        .AF_OFFSET(AF_OFFSET),
        .AE_OFFSET(AE_OFFSET)
    ) u_mq_queue_store (
        .clock(clock),
        .reset_n(reset_n),
        .wr_en(st_wr),
        .wr_q(wq_reg),
        .wr_data(port.write_data),
        .rd_en(st_rd),
        .rd_q(rq_reg),
        .rd_data(st_data),
        .full(q_full),
        .empty(q_empty),
        .almost_full(q_afull),
        .almost_empty(q_aempty)
    );

    // write enable plays no part in selection
    assign wsel = port.write_address_latch;
    assign wmatch = dev_match(port.write_queue_address[`MQ_WADDR_BITS-1:`MQ_WDEV_LSB], id_reg);

    // wq_reg stays the old queue through the selection edge and the next one
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wph_reg <= PH_STEADY;
            wq_reg <= '0;
            wq_new_reg <= '0;
            wact_reg <= 1'b0;
            wact_new_reg <= 1'b0;
        end else begin
            case (wph_reg)
                PH_STEADY: begin
                    if (wsel) begin
                        wq_new_reg <= port.write_queue_address[`MQ_QUEUE_BITS-1:0];
                        wact_new_reg <= wmatch;
                        wph_reg <= PH_TAIL;
                    end
                end
                PH_TAIL: begin
                    // a selection here breaks the spacing and is dropped
                    wq_reg <= wq_new_reg;
                    wact_reg <= wact_new_reg;
                    wph_reg <= PH_STEADY;
                end
                default: begin
                    wph_reg <= PH_STEADY;
                end
            endcase
        end
    end

    // every edge may store a word, the old queue during the switch
    assign st_wr = wact_reg && !port.write_enable_n && !q_full[wq_reg];

    // the flag turns to the new queue one edge before data can go there
    assign fview_q = (wph_reg == PH_TAIL) ? wq_new_reg : wq_reg;
    assign fview_act = (wph_reg == PH_TAIL) ? wact_new_reg : wact_reg;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ff_n_reg <= 1'b1;
            ff_oe_reg <= 1'b0;
        end else begin
            ff_n_reg <= !q_full[fview_q];
            ff_oe_reg <= fview_act;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            paf_sel_reg <= 1'b0;
            paf_reg <= '1;
        end else begin
            if (!port.write_address_latch && port.full_flag_bus_strobe) begin
                paf_sel_reg <= wmatch;
            end
            paf_reg <= ~q_afull;
        end
    end

    assign rsel = port.read_address_latch;
    assign rmatch = dev_match(port.read_queue_address[`MQ_RADDR_BITS-1:`MQ_RDEV_LSB], id_reg);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rph_reg <= PH_STEADY;
            rq_reg <= '0;
            rq_new_reg <= '0;
            rok_reg <= 1'b0;
            rok_new_reg <= 1'b0;
            rdev_reg <= 1'b0;
            rdev_new_reg <= 1'b0;
        end else begin
            case (rph_reg)
                PH_STEADY: begin
                    if (rsel) begin
                        rq_new_reg <= port.read_queue_address[`MQ_QUEUE_BITS-1:0];
                        rok_new_reg <= rmatch && !port.read_queue_address[`MQ_NULL_BIT];
                        rdev_new_reg <= rmatch;
                        rph_reg <= PH_TAIL;
                    end
                end
                PH_TAIL: begin
                    rq_reg <= rq_new_reg;
                    rok_reg <= rok_new_reg;
                    rdev_reg <= rdev_new_reg;
                    rph_reg <= PH_STEADY;
                end
                default: begin
                    rph_reg <= PH_STEADY;
                end
            endcase
        end
    end

    // output register moves when read or holding nothing; the stage ahead refills by fall-through
    assign advance = !port.read_enable_n || !out_v_reg;
    assign direct = advance && !pipe_v_reg;
    assign st_rd = rok_reg && !q_empty[rq_reg] && (!pipe_v_reg || advance);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pipe_reg <= '0;
            pipe_v_reg <= 1'b0;
            out_reg <= '0;
            out_v_reg <= 1'b0;
        end else begin
            if (advance) begin
                if (pipe_v_reg) begin
                    out_reg <= pipe_reg;
                    out_v_reg <= 1'b1;
                end else if (st_rd) begin
                    out_reg <= st_data;
                    out_v_reg <= 1'b1;
                end else begin
                    out_v_reg <= 1'b0;
                end
            end
            if (st_rd && !direct) begin
                pipe_reg <= st_data;
                pipe_v_reg <= 1'b1;
            end else if (advance) begin
                pipe_v_reg <= 1'b0;
            end
        end
    end

    // output enable gates only the drive, never the loading above
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            oe_reg <= 1'b0;
            pae_sel_reg <= 1'b0;
            pae_reg <= '0;
        end else begin
            oe_reg <= rdev_reg && !port.output_enable_n;
            if (!port.read_address_latch && port.empty_flag_bus_strobe) begin
                pae_sel_reg <= rmatch;
            end
            pae_reg <= ~q_aempty;
        end
    end

    assign port.queue_full_flag_n = ff_n_reg;
    assign port.full_flag_oe = ff_oe_reg;
    assign port.almost_full_flag_bus_n = paf_reg;
    assign port.almost_full_oe = paf_sel_reg;
    assign port.read_data = out_reg;
    assign port.read_data_oe = oe_reg;
    assign port.output_valid_flag_n = !out_v_reg;
    assign port.almost_empty_flag_bus_n = pae_reg;
    assign port.almost_empty_oe = pae_sel_reg;

endmodule : mq_device

// >>> design/mq_consts.svh
// constants shared by the multi-queue port-select design
// assumes it is included by bare name from every design file
`ifndef MQ_CONSTS_SVH
`define MQ_CONSTS_SVH

`define MQ_NUM_QUEUES 8
`define MQ_QUEUE_BITS 3
`define MQ_ID_BITS 3
`define MQ_WADDR_BITS 6
`define MQ_RADDR_BITS 7
`define MQ_WDEV_LSB 3
`define MQ_RDEV_LSB 4
`define MQ_NULL_BIT 3
`define MQ_DATA_WIDTH 18
`define MQ_FLAG_OFFSET 8
`define MQ_QUEUE_DEPTH 16
`define MQ_SEL_GAP 2

`endif

// >>> design/mq_pkg.sv
// types and helpers shared by both ends of the queue port
// assumes mq_consts.svh is on the include path
`include "mq_consts.svh"

package mq_pkg;

    typedef logic [`MQ_QUEUE_BITS-1:0] qnum_t;
    typedef logic [`MQ_ID_BITS-1:0] dev_id_t;

    // steady: transfers use the active queue; tail: one more cycle on the old one
    typedef enum logic {
        PH_STEADY,
        PH_TAIL
    } sw_phase_e;

    function automatic logic dev_match(input dev_id_t field, input dev_id_t id);
        dev_match = (field == id);
    endfunction : dev_match

endpackage : mq_pkg

// >>> design/mq_port_if.sv
// write and read port signals between a system controller and a multi-queue device
// assumes both ends run on one common clock; enables tell who drives shared flag nets
`timescale 1ns/1ps
`include "mq_consts.svh"

interface mq_port_if #(parameter int WIDTH = `MQ_DATA_WIDTH);
    // write port
    logic [`MQ_WADDR_BITS-1:0] write_queue_address;
    logic write_address_latch;
    logic full_flag_bus_strobe;
    logic write_enable_n;
    logic [WIDTH-1:0] write_data;
    logic queue_full_flag_n;
    logic full_flag_oe;
    logic [`MQ_NUM_QUEUES-1:0] almost_full_flag_bus_n;
    logic almost_full_oe;
    // read port
    logic [`MQ_RADDR_BITS-1:0] read_queue_address;
    logic read_address_latch;
    logic empty_flag_bus_strobe;
    logic read_enable_n;
    logic output_enable_n;
    logic [WIDTH-1:0] read_data;
    logic read_data_oe;
    logic output_valid_flag_n;
    logic [`MQ_NUM_QUEUES-1:0] almost_empty_flag_bus_n;
    logic almost_empty_oe;

    modport device (
        input write_queue_address, write_address_latch, full_flag_bus_strobe, write_enable_n, write_data,
        output queue_full_flag_n, full_flag_oe, almost_full_flag_bus_n, almost_full_oe,
        input read_queue_address, read_address_latch, empty_flag_bus_strobe, read_enable_n, output_enable_n,
        output read_data, read_data_oe, output_valid_flag_n, almost_empty_flag_bus_n, almost_empty_oe
    );

    modport controller (
        output write_queue_address, write_address_latch, full_flag_bus_strobe, write_enable_n, write_data,
        input queue_full_flag_n, full_flag_oe, almost_full_flag_bus_n, almost_full_oe,
        output read_queue_address, read_address_latch, empty_flag_bus_strobe, read_enable_n, output_enable_n,
        input read_data, read_data_oe, output_valid_flag_n, almost_empty_flag_bus_n, almost_empty_oe
    );

endinterface : mq_port_if

// >>> design/mq_queue_store.sv
// storage for all queues: one shared array, per-queue pointers and fill counts
// assumes DEPTH is a power of two and callers never push a full or pop an empty queue
`timescale 1ns/1ps
`include "mq_consts.svh"

module mq_queue_store #(
    parameter int NQ = `MQ_NUM_QUEUES,
    parameter int DEPTH = `MQ_QUEUE_DEPTH,
    parameter int WIDTH = `MQ_DATA_WIDTH,
    parameter int AF_OFFSET = `MQ_FLAG_OFFSET,
    parameter int AE_OFFSET = `MQ_FLAG_OFFSET
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // push side
    input wire logic wr_en,
    input wire logic [$clog2(NQ)-1:0] wr_q,
    input wire logic [WIDTH-1:0] wr_data,
    // pop side
    input wire logic rd_en,
    input wire logic [$clog2(NQ)-1:0] rd_q,
    output logic [WIDTH-1:0] rd_data,
    // per-queue status
    output logic [NQ-1:0] full,
    output logic [NQ-1:0] empty,
    output logic [NQ-1:0] almost_full,
    output logic [NQ-1:0] almost_empty
);
    localparam int QW = $clog2(NQ);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;

    logic [WIDTH-1:0] mem [NQ*DEPTH];
    logic [PW-1:0] wp_reg [NQ];
    logic [PW-1:0] rp_reg [NQ];
    logic [CW-1:0] cnt_reg [NQ];

    assign rd_data = mem[{rd_q, rp_reg[rd_q]}];

    // memory has no reset: contents are undefined until written
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[{wr_q, wp_reg[wr_q]}] <= wr_data;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NQ; i++) begin
                wp_reg[i] <= '0;
                rp_reg[i] <= '0;
                cnt_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NQ; i++) begin
                if (wr_en && wr_q == QW'(i)) begin
                    wp_reg[i] <= wp_reg[i] + PW'(1);
                end
                if (rd_en && rd_q == QW'(i)) begin
                    rp_reg[i] <= rp_reg[i] + PW'(1);
                end
                if ((wr_en && wr_q == QW'(i)) && !(rd_en && rd_q == QW'(i))) begin
                    cnt_reg[i] <= cnt_reg[i] + CW'(1);
                end else if (!(wr_en && wr_q == QW'(i)) && (rd_en && rd_q == QW'(i))) begin
                    cnt_reg[i] <= cnt_reg[i] - CW'(1);
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NQ; i++) begin
            full[i] = (cnt_reg[i] == CW'(DEPTH));
            empty[i] = (cnt_reg[i] == '0);
            almost_full[i] = (cnt_reg[i] >= CW'(DEPTH - AF_OFFSET));
            almost_empty[i] = (cnt_reg[i] <= CW'(AE_OFFSET));
        end
    end

endmodule : mq_queue_store

// >>> design/mq_controller.sv
// system controller end: turns user requests into queue selections, writes and reads
// assumes the same clock as the device; flag nets are resolved by the surrounding bench
`timescale 1ns/1ps
`include "mq_consts.svh"

module mq_controller
    import mq_pkg::*;
#(
    parameter int WIDTH = `MQ_DATA_WIDTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // write queue selection and flag bus addressing
    input wire logic wsel_req,
    input wire logic [`MQ_WADDR_BITS-1:0] wsel_addr,
    input wire logic wflag_req,
    input wire logic [`MQ_WADDR_BITS-1:0] wflag_addr,
    output logic wsel_ready,
    // write data
    input wire logic wr_valid,
    input wire logic [WIDTH-1:0] wr_data,
    output logic wr_ready,
    // read queue selection and flag bus addressing
    input wire logic rsel_req,
    input wire logic [`MQ_RADDR_BITS-1:0] rsel_addr,
    input wire logic eflag_req,
    input wire logic [`MQ_RADDR_BITS-1:0] eflag_addr,
    output logic rsel_ready,
    // read data
    input wire logic rd_req,
    input wire logic rd_out_enable,
    output logic [WIDTH-1:0] rd_data,
    output logic rd_data_valid,
    // flag bus status
    output logic [`MQ_NUM_QUEUES-1:0] almost_full_flags_n,
    output logic [`MQ_NUM_QUEUES-1:0] almost_empty_flags_n,
    // port towards the device
    mq_port_if.controller port
);
    logic [1:0] wgap_reg, rgap_reg;
    logic wissue, rissue;
    logic latch_w_reg, strobe_w_reg, latch_r_reg, strobe_r_reg;
    logic [`MQ_WADDR_BITS-1:0] waddr_reg;
    logic [`MQ_RADDR_BITS-1:0] raddr_reg;
    logic wen_n_reg, ren_n_reg, oe_n_reg;
    logic [WIDTH-1:0] wdata_reg;

    assign wissue = wsel_req && wsel_ready;
    assign rissue = rsel_req && rsel_ready;

    // selections are spaced; a flag strobe yields to a selection in the same cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wgap_reg <= '0;
            wsel_ready <= 1'b1;
            latch_w_reg <= 1'b0;
            strobe_w_reg <= 1'b0;
            waddr_reg <= '0;
        end else begin
            wgap_reg <= wissue ? 2'(`MQ_SEL_GAP - 1) : (wgap_reg != '0 ? wgap_reg - 2'd1 : '0);
            wsel_ready <= !wissue && (wgap_reg <= 2'd1);
            latch_w_reg <= wissue;
            strobe_w_reg <= wflag_req && !wissue;
            if (wissue) begin
                waddr_reg <= wsel_addr;
            end else if (wflag_req) begin
                waddr_reg <= wflag_addr;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rgap_reg <= '0;
            rsel_ready <= 1'b1;
            latch_r_reg <= 1'b0;
            strobe_r_reg <= 1'b0;
            raddr_reg <= '0;
        end else begin
            rgap_reg <= rissue ? 2'(`MQ_SEL_GAP - 1) : (rgap_reg != '0 ? rgap_reg - 2'd1 : '0);
            rsel_ready <= !rissue && (rgap_reg <= 2'd1);
            latch_r_reg <= rissue;
            strobe_r_reg <= eflag_req && !rissue;
            if (rissue) begin
                raddr_reg <= rsel_addr;
            end else if (eflag_req) begin
                raddr_reg <= eflag_addr;
            end
        end
    end

    // ready follows the registered full flag, so it lags a switch by a cycle;
    // the device still blocks a word aimed at a full queue and that word is lost
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wen_n_reg <= 1'b1;
            wdata_reg <= '0;
            wr_ready <= 1'b0;
        end else begin
            wr_ready <= port.full_flag_oe && port.queue_full_flag_n;
            wen_n_reg <= !(wr_valid && wr_ready);
            wdata_reg <= wr_data;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ren_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            rd_data <= '0;
            rd_data_valid <= 1'b0;
        end else begin
            ren_n_reg <= !rd_req;
            oe_n_reg <= !rd_out_enable;
            rd_data_valid <= !ren_n_reg && !port.output_valid_flag_n && port.read_data_oe;
            if (!ren_n_reg && !port.output_valid_flag_n && port.read_data_oe) begin
                rd_data <= port.read_data;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            almost_full_flags_n <= '1;
            almost_empty_flags_n <= '1;
        end else begin
            if (port.almost_full_oe) begin
                almost_full_flags_n <= port.almost_full_flag_bus_n;
            end
            if (port.almost_empty_oe) begin
                almost_empty_flags_n <= port.almost_empty_flag_bus_n;
            end
        end
    end

    assign port.write_queue_address = waddr_reg;
    assign port.write_address_latch = latch_w_reg;
    assign port.full_flag_bus_strobe = strobe_w_reg;
    assign port.write_enable_n = wen_n_reg;
    assign port.write_data = wdata_reg;
    assign port.read_queue_address = raddr_reg;
    assign port.read_address_latch = latch_r_reg;
    assign port.empty_flag_bus_strobe = strobe_r_reg;
    assign port.read_enable_n = ren_n_reg;
    assign port.output_enable_n = oe_n_reg;

endmodule : mq_controller

// >>> tb/mq_port_properties.sv
// concurrent checks on the port joining controller and device
// assumes one clock, async active-low reset, device strapped to DEV_ID
`timescale 1ns/1ps
`include "mq_consts.svh"

module mq_port_properties
    import mq_pkg::*;
#(
    parameter int WIDTH = `MQ_DATA_WIDTH,
    parameter logic [2:0] DEV_ID = 3'h0
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // write port
    input wire logic [`MQ_WADDR_BITS-1:0] write_queue_address,
    input wire logic write_address_latch,
    input wire logic full_flag_bus_strobe,
    input wire logic full_flag_oe,
    input wire logic almost_full_oe,
    // read port
    input wire logic [`MQ_RADDR_BITS-1:0] read_queue_address,
    input wire logic read_address_latch,
    input wire logic empty_flag_bus_strobe,
    input wire logic read_enable_n,
    input wire logic output_enable_n,
    input wire logic [WIDTH-1:0] read_data,
    input wire logic read_data_oe,
    input wire logic output_valid_flag_n,
    input wire logic almost_empty_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_wsel_spacing: assert property (write_address_latch |=> !write_address_latch)
        else $error("write selections too close");
    a_rsel_spacing: assert property (read_address_latch |=> !read_address_latch)
        else $error("read selections too close");
    a_wstrobe_excl: assert property (!(write_address_latch && full_flag_bus_strobe))
        else $error("write latch and strobe together");
    a_rstrobe_excl: assert property (!(read_address_latch && empty_flag_bus_strobe))
        else $error("read latch and strobe together");
    a_full_oe_select: assert property (write_address_latch |-> ##2
        full_flag_oe == ($past(write_queue_address[5:3], 2) == DEV_ID))
        else $error("full flag drive wrong after selection");
    a_af_bus_drive: assert property (full_flag_bus_strobe && !write_address_latch |=>
        almost_full_oe == ($past(write_queue_address[5:3]) == DEV_ID))
        else $error("almost-full bus drive wrong");
    a_ae_bus_drive: assert property (empty_flag_bus_strobe && !read_address_latch |=>
        almost_empty_oe == ($past(read_queue_address[6:4]) == DEV_ID))
        else $error("almost-empty bus drive wrong");
    // the drain needs the enable held, or a valid word may legally sit
    a_null_invalid: assert property ((read_address_latch && read_queue_address[3]) ##1
        (!read_enable_n) [*4] |-> ##[0:3] output_valid_flag_n)
        else $error("null queue left output marked valid");
    a_ov_hold: assert property (output_valid_flag_n && $past(output_valid_flag_n) |->
        $stable(read_data))
        else $error("invalid output word changed");
    a_oe_gate: assert property (output_enable_n |=> !read_data_oe)
        else $error("read data driven while disabled");
endmodule : mq_port_properties

// >>> tb/multi_queue_port_select_tb.sv
// self-checking bench: controller and device joined by the port interface
// assumes device identity strapped to zero and shortened queue depth
`timescale 1ns/1ps
`include "mq_consts.svh"

module multi_queue_port_select_tb
    import mq_pkg::*;
;
    // short queues so the full case is reached quickly
    localparam int DEPTH = 4;
    logic clock = 1'b0, reset_n = 1'b0;
    logic wsel_req = 1'b0, wflag_req = 1'b0, wr_valid = 1'b0;
    logic rsel_req = 1'b0, eflag_req = 1'b0, rd_req = 1'b0, rd_out_enable = 1'b1;
    logic [5:0] wsel_addr = 6'h00, wflag_addr = 6'h00;
    logic [6:0] rsel_addr = 7'h00, eflag_addr = 7'h00;
    logic [17:0] wr_data = 18'h00000;
    logic wsel_ready, wr_ready, rsel_ready, rd_data_valid;
    logic [17:0] rd_data;
    logic [7:0] almost_full_flags_n, almost_empty_flags_n;
    logic [17:0] model[9][$];
    int bad_count = 0, samples_checked = 0;

    mq_port_if #(.WIDTH(18)) port_if();
    mq_device #(.DEPTH(DEPTH), .AF_OFFSET(1), .AE_OFFSET(1)) u_mq_device(.clock, .reset_n,
        .device_identity_pin(3'h0), .port(port_if.device));
    mq_controller u_mq_controller(.clock, .reset_n, .wsel_req, .wsel_addr, .wflag_req, .wflag_addr,
        .wsel_ready, .wr_valid, .wr_data, .wr_ready, .rsel_req, .rsel_addr, .eflag_req, .eflag_addr,
        .rsel_ready, .rd_req, .rd_out_enable, .rd_data, .rd_data_valid, .almost_full_flags_n,
        .almost_empty_flags_n, .port(port_if.controller));
    mq_port_properties u_mq_port_properties(.clock, .reset_n,
        .write_queue_address(port_if.write_queue_address), .write_address_latch(port_if.write_address_latch),
        .full_flag_bus_strobe(port_if.full_flag_bus_strobe), .full_flag_oe(port_if.full_flag_oe),
        .almost_full_oe(port_if.almost_full_oe), .read_queue_address(port_if.read_queue_address),
        .read_address_latch(port_if.read_address_latch), .empty_flag_bus_strobe(port_if.empty_flag_bus_strobe),
        .read_enable_n(port_if.read_enable_n), .output_enable_n(port_if.output_enable_n),
        .read_data(port_if.read_data), .read_data_oe(port_if.read_data_oe),
        .output_valid_flag_n(port_if.output_valid_flag_n), .almost_empty_oe(port_if.almost_empty_oe));

    always #50 clock = ~clock;

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wsel(input logic [5:0] a);
        wsel_addr <= a;
        wsel_req <= 1'b1;
        repeat (20) begin
            @(posedge clock);
            if (wsel_ready === 1'b1) break;
        end
        wsel_req <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : wsel

    // wr_valid stays up so back-to-back words leave no gap
    task automatic put(input logic sel, input logic [5:0] a, input logic [17:0] d);
        wr_data <= d;
        wr_valid <= 1'b1;
        if (sel) begin
            wsel_addr <= a;
            wsel_req <= 1'b1;
        end
        repeat (20) begin
            @(posedge clock);
            if (wr_ready === 1'b1) break;
        end
        // the word leaves on this edge, so the selection must be taken on it too
        if (sel) begin
            wsel_req <= 1'b0;
            chk(18'(wsel_ready), 18'h00001);
        end
    endtask : put

    // an unknown expectation flags any word beyond the model
    task automatic rdq(input logic [6:0] a, input int q);
        rsel_addr <= a;
        rsel_req <= 1'b1;
        repeat (20) begin
            @(posedge clock);
            if (rsel_ready === 1'b1) break;
        end
        rsel_req <= 1'b0;
        rd_req <= 1'b1;
        repeat (DEPTH + 12) begin
            @(posedge clock);
            if (rd_data_valid === 1'b1) chk(rd_data, model[q].size() > 0 ? model[q].pop_front() : 18'hxxxxx);
        end
        rd_req <= 1'b0;
        chk(18'(model[q].size()), 18'h00000);
        repeat (2) @(posedge clock);
    endtask : rdq

    task automatic results();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    initial begin
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        wsel(6'h01);
        put(1'b0, 6'h00, 18'h00101);
        put(1'b1, 6'h02, 18'h00102);
        put(1'b0, 6'h00, 18'h00103);
        put(1'b0, 6'h00, 18'h00104);
        wr_valid <= 1'b0;
        model[1] = '{18'h00101, 18'h00102, 18'h00103};
        model[2] = '{18'h00104};
        wsel(6'h0c);
        put(1'b0, 6'h00, 18'h001ff);
        wr_valid <= 1'b0;
        wsel(6'h03);
        for (int i = 0; i < DEPTH + 2; i++) begin
            put(1'b0, 6'h00, 18'h00300 + 18'(i));
            if (i < DEPTH) model[3].push_back(18'h00300 + 18'(i));
        end
        wr_valid <= 1'b0;
        wflag_req <= 1'b1;
        eflag_req <= 1'b1;
        @(posedge clock);
        wflag_req <= 1'b0;
        eflag_req <= 1'b0;
        repeat (4) @(posedge clock);
        chk(18'(almost_full_flags_n[3]), 18'h00000);
        chk(18'(almost_empty_flags_n[0]), 18'h00000);
        chk(18'(port_if.queue_full_flag_n), 18'h00000);
        rdq(7'h01, 1);
        rd_out_enable <= 1'b0;
        repeat (3) @(posedge clock);
        rd_out_enable <= 1'b1;
        rdq(7'h02, 2);
        rdq(7'h0b, 8);
        rdq(7'h13, 8);
        rdq(7'h03, 3);
        rdq(7'h04, 4);
        results();
    end

    initial begin
        repeat (3000) @(posedge clock);
        bad_count++;
        results();
    end
endmodule : multi_queue_port_select_tb
